// ---- design/ssp_pkg.sv ----
// Shared constants for the split-data-line serial port: byte layouts,
// register select codes and host bit timing.
// Assumes a 125 MHz core clock at both ends.
package ssp_pkg;

  localparam int unsigned CORE_CLK_MHZ = 125;
  // Quarter of one host serial clock period, 400 kHz bus
  localparam int unsigned SCL_QUARTER_NS = 625;
  localparam int unsigned SCL_QUARTER_CYC = (SCL_QUARTER_NS * CORE_CLK_MHZ) / 1000;

  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned ADDR_PINS = 5;

  // Address byte: direction in bit 0, compared select bits 5..1
  localparam int unsigned DIR_POS = 0;
  localparam int unsigned SEL_PIN_LSB = 1;
  localparam int unsigned SEL_PIN_MSB = 5;

  // Port/register select byte
  localparam int unsigned REG_LSB = 3;
  localparam int unsigned REG_MSB = 6;
  localparam int unsigned PORT_LSB = 0;
  localparam int unsigned PORT_MSB = 1;
  localparam logic [7:0] SELECT_RESET = 8'h00;

  typedef enum logic [3:0] {
    SSP_REG_COMMON_READ = 4'h0,
    SSP_REG_COMMON_CTRL = 4'h1,
    SSP_REG_PORT_CTRL1 = 4'h2,
    SSP_REG_PORT_CTRL2 = 4'h3,
    SSP_REG_PORT_STAT1 = 4'h4,
    SSP_REG_PORT_STAT2 = 4'h5,
    SSP_REG_DISC_LO = 4'h6,
    SSP_REG_DISC_HI = 4'h7,
    SSP_REG_VOLT_LO = 4'h8,
    SSP_REG_VOLT_HI = 4'h9,
    SSP_REG_CURR_LO = 4'hA,
    SSP_REG_CURR_HI = 4'hB,
    SSP_REG_TEMP_LO = 4'hC,
    SSP_REG_TEMP_HI = 4'hD,
    SSP_REG_UNUSED = 4'hE,
    SSP_REG_TEST = 4'hF
  } ssp_reg_e;

endpackage

// ---- design/ssp_if.sv ----
// Two-wire link with the data line split into host-to-device and
// device-to-host paths; the device path is open drain with a pull-up.
// Assumes the bench ties both ends to one instance.
`timescale 1ns/1ps
`default_nettype none
interface ssp_if;
  logic scl;
  logic sda_i;
  logic sda_o_out;
  logic sda_o_oe_n;
  logic sda_o_line;

  // Pull-up when the device releases its output
  assign sda_o_line = sda_o_oe_n ? 1'b1 : sda_o_out;

  modport dev (
    input scl,
    input sda_i,
    output sda_o_out,
    output sda_o_oe_n
  );

  modport host (
    output scl,
    output sda_i,
    input sda_o_line
  );
endinterface
`default_nettype wire

// ---- design/ssp_dev.sv ----
// Device end of the split-data-line serial port: slave byte engine with
// register select latch and a register access port toward the port logic.
// Assumes scl and sda_i come from another domain and change slowly
// compared with core_clk (at least four core cycles per level).
// Behaviour
// - Separate data input and open-drain data output.
// - Clock is input only; slave only.
// - Read is select frame, then read frame.
// - Write is address, select, data, stop.
// - Held in reset until supplies ready.
// - Start and stop seen while clock high.
// - Only the master makes start and stop.
// - Five select bits must match address pins.
// - Two top address bits are not compared.
// - Address LSB one reads, zero writes.
// - Matching address acknowledged low, ninth clock.
// - Select byte latched at eighth falling edge.
// - Data byte written to selected register if writable, acknowledged.
// - Common writes hit all ports; others one.
// - Master ends a write with stop.
// - Read frame address acknowledged again.
// - Read byte shifted out MSB first.
// - Master answers read byte high, then stops.
// - Select bits 6..3 register, 1..0 port.
// - Register codes decode to documented targets.
`timescale 1ns/1ps
`default_nettype none
module ssp_dev #(
  parameter int unsigned PORTS = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic supplies_ok,
  input wire logic [ssp_pkg::ADDR_PINS-1:0] slave_select_pins,
  ssp_if.dev bus,
  output logic wr_valid,
  output logic [3:0] wr_reg,
  output logic [PORTS-1:0] wr_port_mask,
  output logic [7:0] wr_data,
  output logic [3:0] sel_reg,
  output logic [1:0] sel_port,
  output logic rd_strobe,
  input wire logic [7:0] rd_data
);

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_SEL = 9'h008,
    ST_SEL_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RDATA_ACK = 9'h100
  } ssp_dev_state_e;

  function automatic logic addr_hit(input logic [7:0] a, input logic [4:0] pins);
    // Bits 7 and 6 are left out of the compare on purpose
    addr_hit = (a[ssp_pkg::SEL_PIN_MSB:ssp_pkg::SEL_PIN_LSB] == pins);
  endfunction

  function automatic logic is_common(input logic [3:0] r);
    is_common = (r == ssp_pkg::SSP_REG_COMMON_READ) || (r == ssp_pkg::SSP_REG_COMMON_CTRL)
      || (r == ssp_pkg::SSP_REG_TEST);
  endfunction

  function automatic logic is_writable(input logic [3:0] r);
    is_writable = (r == ssp_pkg::SSP_REG_COMMON_CTRL) || (r == ssp_pkg::SSP_REG_PORT_CTRL1)
      || (r == ssp_pkg::SSP_REG_PORT_CTRL2) || (r == ssp_pkg::SSP_REG_TEST);
  endfunction

  // Power-on qualifier; the link logic stays in reset until it is seen
  logic [1:0] por_sync;
  logic run;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      por_sync <= 2'h0;
    end else begin
      por_sync <= {por_sync[0], supplies_ok};
    end
  end

  assign run = resetn & por_sync[1];

  // Two-stage synchronisers, then one more stage for edge finding
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;

  always_ff @(posedge core_clk) begin
    if (!run) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda_i};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
      pin_s1 <= slave_select_pins;
      pin_s2 <= pin_s1;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_sync[1] & ~scl_q;
  assign scl_fall = ~scl_sync[1] & scl_q;
  assign start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop_det = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

  ssp_dev_state_e state;
  ssp_dev_state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic dir;
  logic next_dir;
  logic [7:0] sel;
  logic [7:0] next_sel;
  logic oe_n;
  logic next_oe_n;
  logic next_wr_valid;
  logic [7:0] next_wr_data;
  logic [PORTS-1:0] next_wr_port_mask;
  logic next_rd_strobe;
  logic rx_state;
  logic rx_done;

  assign rx_state = (state == ST_ADDR) || (state == ST_SEL) || (state == ST_WDATA);
  assign rx_done = rx_state && scl_fall && (cnt == 4'(ssp_pkg::BYTE_BITS));

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_dir = dir;
    next_sel = sel;
    next_oe_n = oe_n;
    next_wr_valid = 1'b0;
    next_wr_data = wr_data;
    next_wr_port_mask = wr_port_mask;
    next_rd_strobe = 1'b0;
    if (stop_det) begin
      // Selection is kept so a later read frame uses it
      next_state = ST_IDLE;
      next_oe_n = 1'b1;
    end else if (start_det) begin
      next_state = ST_ADDR;
      next_cnt = 4'h0;
      next_oe_n = 1'b1;
    end else begin
      if (rx_state && scl_rise && cnt < 4'(ssp_pkg::BYTE_BITS)) begin
        next_shreg = {shreg[6:0], sda_sync[1]};
        next_cnt = cnt + 4'h1;
      end
      case (state)
        ST_ADDR: begin
          if (rx_done) begin
            if (addr_hit(shreg, pin_s2)) begin
              next_oe_n = 1'b0;
              next_dir = shreg[ssp_pkg::DIR_POS];
              next_state = ST_ADDR_ACK;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (dir) begin
              next_shreg = rd_data;
              next_oe_n = rd_data[7];
              next_rd_strobe = 1'b1;
              next_state = ST_RDATA;
            end else begin
              next_oe_n = 1'b1;
              next_state = ST_SEL;
            end
          end
        end
        ST_SEL: begin
          if (rx_done) begin
            next_sel = shreg;
            next_oe_n = 1'b0;
            next_state = ST_SEL_ACK;
          end
        end
        ST_SEL_ACK: begin
          if (scl_fall) begin
            next_oe_n = 1'b1;
            next_cnt = 4'h0;
            next_state = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (rx_done) begin
            next_wr_valid = is_writable(sel[ssp_pkg::REG_MSB:ssp_pkg::REG_LSB]);
            next_wr_data = shreg;
            if (is_common(sel[ssp_pkg::REG_MSB:ssp_pkg::REG_LSB])) begin
              next_wr_port_mask = '1;
            end else begin
              next_wr_port_mask = PORTS'(1) << sel[ssp_pkg::PORT_MSB:ssp_pkg::PORT_LSB];
            end
            next_oe_n = 1'b0;
            next_state = ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: begin
          // Extra bytes are ignored until the master's next start
          if (scl_fall) begin
            next_oe_n = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt == 4'(ssp_pkg::BYTE_BITS - 1)) begin
              next_oe_n = 1'b1;
              next_state = ST_RDATA_ACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe_n = shreg[6];
              next_cnt = cnt + 4'h1;
            end
          end
        end
        ST_RDATA_ACK: begin
          // Host answer is not checked; a single byte is always sent
          if (scl_fall) begin
            next_state = ST_IDLE;
          end
        end
        ST_IDLE: begin
          next_oe_n = 1'b1;
        end
        default: begin
          next_state = ST_IDLE;
          next_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!run) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      dir <= 1'b0;
      sel <= ssp_pkg::SELECT_RESET;
      oe_n <= 1'b1;
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
      wr_port_mask <= '0;
      rd_strobe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      dir <= next_dir;
      sel <= next_sel;
      oe_n <= next_oe_n;
      wr_valid <= next_wr_valid;
      wr_data <= next_wr_data;
      wr_port_mask <= next_wr_port_mask;
      rd_strobe <= next_rd_strobe;
    end
  end

  // Open drain: only ever pulls low
  assign bus.sda_o_out = 1'b0;
  assign bus.sda_o_oe_n = oe_n;
  assign wr_reg = sel[ssp_pkg::REG_MSB:ssp_pkg::REG_LSB];
  assign sel_reg = sel[ssp_pkg::REG_MSB:ssp_pkg::REG_LSB];
  assign sel_port = sel[ssp_pkg::PORT_MSB:ssp_pkg::PORT_LSB];

endmodule
`default_nettype wire

// ---- design/ssp_host.sv ----
// Host end of the split-data-line serial port: bus master that runs one
// register write or one register read per command.
// Assumes the device answers on sda_o_line, sampled through two flops.
`timescale 1ns/1ps
`default_nettype none
module ssp_host #(
  parameter int unsigned QUARTER_CYC = ssp_pkg::SCL_QUARTER_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  ssp_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_sel,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [7:0] rsp_data
);

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_START = 4'h2,
    HS_XFER = 4'h4,
    HS_STOP = 4'h8
  } ssp_host_state_e;

  logic [1:0] sdo_sync;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sdo_sync <= 2'h3;
    end else begin
      sdo_sync <= {sdo_sync[0], bus.sda_o_line};
    end
  end

  ssp_host_state_e state;
  ssp_host_state_e next_state;
  logic [15:0] qcnt;
  logic [15:0] next_qcnt;
  logic [1:0] ph;
  logic [1:0] next_ph;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [1:0] idx;
  logic [1:0] next_idx;
  logic frame;
  logic next_frame;
  logic is_read;
  logic next_is_read;
  logic nack;
  logic next_nack;
  logic [6:0] addr;
  logic [6:0] next_addr;
  logic [7:0] sel;
  logic [7:0] next_sel;
  logic [7:0] wdata;
  logic [7:0] next_wdata;
  logic [7:0] txs;
  logic [7:0] next_txs;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic scl;
  logic next_scl;
  logic sda;
  logic next_sda;
  logic next_rsp_valid;
  logic next_rsp_nack;
  logic [7:0] next_rsp_data;
  logic tick;
  logic last_byte;
  logic rd_byte;

  // Byte sent at a given place; the read-frame data byte is all ones
  function automatic logic [7:0] tx_byte(input logic fr, input logic [1:0] i, input logic [6:0] a,
                                         input logic [7:0] s, input logic [7:0] w);
    if (i == 2'h0) begin
      tx_byte = {a, fr};
    end else if (fr) begin
      tx_byte = 8'hFF;
    end else if (i == 2'h1) begin
      tx_byte = s;
    end else begin
      tx_byte = w;
    end
  endfunction

  assign tick = (qcnt == 16'(QUARTER_CYC - 1));
  assign last_byte = is_read ? (idx == 2'h1) : (idx == 2'h2);
  assign rd_byte = frame && (idx == 2'h1);
  assign cmd_ready = (state == HS_IDLE);

  always_comb begin
    next_state = state;
    next_qcnt = 16'h0000;
    next_ph = ph;
    next_bit_cnt = bit_cnt;
    next_idx = idx;
    next_frame = frame;
    next_is_read = is_read;
    next_nack = nack;
    next_addr = addr;
    next_sel = sel;
    next_wdata = wdata;
    next_txs = txs;
    next_rx = rx;
    next_scl = scl;
    next_sda = sda;
    next_rsp_valid = 1'b0;
    next_rsp_nack = rsp_nack;
    next_rsp_data = rsp_data;
    if (state == HS_IDLE) begin
      if (cmd_valid) begin
        next_state = HS_START;
        next_ph = 2'h0;
        next_frame = 1'b0;
        next_nack = 1'b0;
        next_is_read = cmd_read;
        next_addr = cmd_addr;
        next_sel = cmd_sel;
        next_wdata = cmd_wdata;
      end
    end else if (!tick) begin
      next_qcnt = qcnt + 16'h0001;
    end else begin
      next_ph = ph + 2'h1;
      case (state)
        HS_START: begin
          case (ph)
            2'h0: begin
              next_scl = 1'b1;
              next_sda = 1'b1;
            end
            2'h1: next_sda = 1'b0;
            2'h2: next_scl = 1'b0;
            default: begin
              next_txs = tx_byte(frame, 2'h0, addr, sel, wdata);
              next_idx = 2'h0;
              next_bit_cnt = 4'h0;
              next_state = HS_XFER;
            end
          endcase
        end
        HS_XFER: begin
          case (ph)
            // Ack slot and read data are released high
            2'h0: next_sda = (bit_cnt == 4'(ssp_pkg::BYTE_BITS)) ? 1'b1 : txs[7];
            2'h1: next_scl = 1'b1;
            2'h2: begin
              if (bit_cnt < 4'(ssp_pkg::BYTE_BITS)) begin
                next_rx = {rx[6:0], sdo_sync[1]};
              end else if (!rd_byte && sdo_sync[1]) begin
                next_nack = 1'b1;
              end
            end
            default: begin
              next_scl = 1'b0;
              if (bit_cnt < 4'(ssp_pkg::BYTE_BITS)) begin
                next_txs = {txs[6:0], 1'b1};
                next_bit_cnt = bit_cnt + 4'h1;
              end else if (nack || last_byte) begin
                next_state = HS_STOP;
              end else begin
                next_idx = idx + 2'h1;
                next_txs = tx_byte(frame, idx + 2'h1, addr, sel, wdata);
                next_bit_cnt = 4'h0;
              end
            end
          endcase
        end
        HS_STOP: begin
          case (ph)
            2'h0: next_sda = 1'b0;
            2'h1: next_scl = 1'b1;
            2'h2: next_sda = 1'b1;
            default: begin
              if (is_read && !frame && !nack) begin
                next_frame = 1'b1;
                next_state = HS_START;
              end else begin
                next_state = HS_IDLE;
                next_rsp_valid = 1'b1;
                next_rsp_nack = nack;
                next_rsp_data = rx;
              end
            end
          endcase
        end
        default: next_state = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= HS_IDLE;
      qcnt <= 16'h0000;
      ph <= 2'h0;
      bit_cnt <= 4'h0;
      idx <= 2'h0;
      frame <= 1'b0;
      is_read <= 1'b0;
      nack <= 1'b0;
      addr <= 7'h00;
      sel <= 8'h00;
      wdata <= 8'h00;
      txs <= 8'hFF;
      rx <= 8'h00;
      scl <= 1'b1;
      sda <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      state <= next_state;
      qcnt <= next_qcnt;
      ph <= next_ph;
      bit_cnt <= next_bit_cnt;
      idx <= next_idx;
      frame <= next_frame;
      is_read <= next_is_read;
      nack <= next_nack;
      addr <= next_addr;
      sel <= next_sel;
      wdata <= next_wdata;
      txs <= next_txs;
      rx <= next_rx;
      scl <= next_scl;
      sda <= next_sda;
      rsp_valid <= next_rsp_valid;
      rsp_nack <= next_rsp_nack;
      rsp_data <= next_rsp_data;
    end
  end

  assign bus.scl = scl;
  assign bus.sda_i = sda;

endmodule
`default_nettype wire

// ---- bench/ssp_sva.sv ----
// Checker for the device end of the split-data-line serial link.
// Assumes scl and sda_i come from host flops on core_clk.
`timescale 1ns/1ps
`default_nettype none
module ssp_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic supplies_ok,
  input wire logic [ssp_pkg::ADDR_PINS-1:0] slave_select_pins,
  input wire logic [7:0] rd_data,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o_out,
  input wire logic sda_o_oe_n,
  input wire logic sda_o_line
);
  logic scl_q, sda_q, matched, rd_fr, scl_rise, scl_fall, start;
  logic [3:0] cnt, scl_h;
  logic [1:0] idx;
  logic [7:0] sh, cap;

  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start = scl && scl_q && sda_q && !sda_i;

  // Shadow decoder of the frame, so acks can be tied to the bits that caused them
  always_ff @(posedge core_clk) begin
    scl_q <= scl;
    sda_q <= sda_i;
    scl_h <= {scl_h[2:0], scl};
    if (!resetn || start) begin
      cnt <= 4'h0;
      idx <= 2'h0;
      matched <= 1'b0;
    end else if (scl_rise) begin
      if (cnt == 4'h8) begin
        cnt <= 4'h0;
        if (idx != 2'h3) idx <= idx + 2'h1;
      end else begin
        cnt <= cnt + 4'h1;
        sh <= {sh[6:0], sda_i};
      end
      if (cnt == 4'h8 && idx == 2'h0) begin
        matched <= (sh[5:1] == slave_select_pins);
        rd_fr <= sh[0];
      end
    end
    if (scl_fall && cnt == 4'h0 && idx == 2'h1) cap <= rd_data;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn || !supplies_ok);

  a_open_drain: assert property (!sda_o_oe_n |-> sda_o_out == 1'b0)
    else $error("device drives its data output high");
  a_supply_hold: assert property (disable iff (!resetn) !supplies_ok [*4] |-> sda_o_oe_n)
    else $error("data output pulled while supplies are down");
  a_reset_idle: assert property ($rose(resetn) |-> sda_o_oe_n)
    else $error("data output pulled right after reset");
  a_steady_clock_high: assert property (scl_h == 4'hF |-> $stable(sda_o_oe_n))
    else $error("data output changed while clock high");
  a_addr_ack: assert property (scl_rise && cnt == 4'h8 && idx == 2'h0 |-> sda_o_oe_n == (sh[5:1] != slave_select_pins))
    else $error("address acknowledge does not follow select pins");
  a_select_ack: assert property (scl_rise && cnt == 4'h8 && idx == 2'h1 && matched && !rd_fr |-> !sda_o_oe_n)
    else $error("select byte not acknowledged");
  a_data_ack: assert property (scl_rise && cnt == 4'h8 && idx == 2'h2 && matched && !rd_fr |-> !sda_o_oe_n)
    else $error("data byte not acknowledged");
  a_mismatch_quiet: assert property (idx != 2'h0 && !matched |-> sda_o_oe_n)
    else $error("unaddressed device pulled its output");
  a_read_bit: assert property (scl_rise && cnt < 4'h8 && idx == 2'h1 && matched && rd_fr |-> sda_o_line == cap[3'h7 - cnt[2:0]])
    else $error("read bit differs from selected register");
  a_read_release: assert property (scl_rise && cnt == 4'h8 && idx == 2'h1 && rd_fr |-> sda_o_oe_n)
    else $error("device holds output in host acknowledge slot");

  c_write: cover property (scl_rise && cnt == 4'h8 && idx == 2'h2 && matched);
  c_read: cover property (scl_rise && idx == 2'h1 && matched && rd_fr);
  c_mismatch: cover property (scl_rise && cnt == 4'h8 && idx == 2'h0 && sh[5:1] != slave_select_pins);
endmodule
`default_nettype wire

// ---- bench/ssp_test.sv ----
// Bench joining host and device ends on one link; commands go in at the host,
// write strobes come out of the device and read data returns to the host.
// Assumes a short quarter period so one link bit spans twenty core cycles.
`timescale 1ns/1ps
`default_nettype none
module ssp_test;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic supplies_ok = 1'b1;
  logic [ssp_pkg::ADDR_PINS-1:0] pins = 5'h15;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_sel = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_nack, wr_valid, rd_strobe;
  logic [7:0] rsp_data, wr_data, rd_data, cap_data, mon_addr;
  logic [3:0] wr_reg, wr_port_mask, sel_reg, cap_reg, cap_mask;
  logic [1:0] sel_port;
  int mon_n = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int w0, r0;
  int fails = 0;
  int n_checks = 0;

  always #4 core_clk = ~core_clk;

  function automatic logic [7:0] rd_model(input logic [3:0] r, input logic [1:0] p);
    return {r, 2'b01, p} ^ 8'hC3;
  endfunction
  // Register contents as the port logic would present them
  assign rd_data = rd_model(sel_reg, sel_port);

  ssp_if bus ();
  ssp_dev #(.PORTS(4)) ssp_dev_inst (.core_clk(core_clk), .resetn(resetn), .supplies_ok(supplies_ok),
    .slave_select_pins(pins), .bus(bus.dev), .wr_valid(wr_valid), .wr_reg(wr_reg), .wr_port_mask(wr_port_mask),
    .wr_data(wr_data), .sel_reg(sel_reg), .sel_port(sel_port), .rd_strobe(rd_strobe), .rd_data(rd_data));
  ssp_host #(.QUARTER_CYC(5)) ssp_host_inst (.core_clk(core_clk), .resetn(resetn), .bus(bus.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_data(rsp_data));
  ssp_sva ssp_sva_inst (.core_clk(core_clk), .resetn(resetn), .supplies_ok(supplies_ok),
    .slave_select_pins(pins), .rd_data(rd_data), .scl(bus.scl), .sda_i(bus.sda_i), .sda_o_out(bus.sda_o_out),
    .sda_o_oe_n(bus.sda_o_oe_n), .sda_o_line(bus.sda_o_line));

  // Wire monitor: first byte and clock count of the latest frame
  always @(negedge bus.sda_i) if (bus.scl === 1'b1) mon_n = 0;
  always @(posedge bus.scl) begin
    if (mon_n < 8) mon_addr = {mon_addr[6:0], bus.sda_i};
    mon_n++;
  end
  // Falling edge keeps the strobe sampling clear of the edge that launches it
  always @(negedge core_clk) begin
    if (wr_valid === 1'b1) begin
      wr_cnt++;
      cap_reg = wr_reg;
      cap_mask = wr_port_mask;
      cap_data = wr_data;
    end
    if (rd_strobe === 1'b1) rd_cnt++;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_cmd(input logic rd, input logic [6:0] a, input logic [7:0] s, input logic [7:0] w);
    int n;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_sel = s;
    cmd_wdata = w;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 3000) begin
      fails++;
      close_out();
    end
    chk("idle_levels", {5'h00, bus.scl, bus.sda_i, bus.sda_o_line}, 8'h07);
  endtask

  // Bits 7 and 2 of the select byte are set to show they are ignored
  task automatic wr_case(input logic [1:0] sp, input logic [3:0] r, input logic [1:0] p, input logic [7:0] d);
    logic ok;
    w0 = wr_cnt;
    ok = (r == 4'h1 || r == 4'h2 || r == 4'h3 || r == 4'hF);
    do_cmd(1'b0, {sp, pins}, {1'b1, r, 1'b1, p}, d);
    chk("wr_nack", {7'h00, rsp_nack}, 8'h00);
    // Three nine-clock bytes plus the rising clock of the stop
    chk("wr_frame_clocks", 8'(mon_n), 8'h1C);
    chk("wr_addr_byte", mon_addr, {sp, pins, 1'b0});
    chk("sel", {sel_reg, 2'b00, sel_port}, {r, 2'b00, p});
    chk("wr_count", 8'(wr_cnt - w0), {7'h00, ok});
    if (ok) begin
      chk("wr_reg", {4'h0, cap_reg}, {4'h0, r});
      chk("wr_mask", {4'h0, cap_mask}, (r == 4'h1 || r == 4'hF) ? 8'h0F : 8'h01 << p);
      chk("wr_data", cap_data, d);
    end
  endtask

  task automatic rd_case(input logic [3:0] r, input logic [1:0] p);
    r0 = rd_cnt;
    do_cmd(1'b1, {2'b01, pins}, {1'b0, r, 1'b0, p}, 8'h00);
    chk("rd_nack", {7'h00, rsp_nack}, 8'h00);
    chk("rd_frame_clocks", 8'(mon_n), 8'h13);
    chk("rd_addr_byte", mon_addr, {2'b01, pins, 1'b1});
    chk("rd_data", rsp_data, rd_model(r, p));
    chk("rd_strobes", 8'(rd_cnt - r0), 8'h01);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    for (int i = 0; i < 4; i++) wr_case(2'(i), 4'h3, 2'(i), 8'hA0 + 8'(i));
    $display("test spare_bits done");
    for (int i = 0; i < 16; i++) wr_case(2'b10, 4'(i), 2'(i / 4), 8'h5A ^ 8'(i));
    $display("test register_codes done");
    for (int i = 0; i < 16; i++) rd_case(4'(i), 2'(i));
    $display("test reads done");
    for (int i = 0; i < 5; i++) begin
      w0 = wr_cnt;
      do_cmd(1'(i % 2), {2'b00, pins ^ (5'h01 << i)}, 8'h08, 8'hFF);
      chk("other_nack", {7'h00, rsp_nack}, 8'h01);
      chk("other_writes", 8'(wr_cnt - w0), 8'h00);
    end
    $display("test address_mismatch done");
    pins = 5'h0A;
    wr_case(2'b11, 4'h2, 2'h3, 8'hE7);
    rd_case(4'h4, 2'h2);
    $display("test new_pins done");
    #1 supplies_ok = 1'b0;
    repeat (4) @(posedge core_clk);
    w0 = wr_cnt;
    do_cmd(1'b0, {2'b00, pins}, 8'h10, 8'h11);
    chk("unpowered_nack", {7'h00, rsp_nack}, 8'h01);
    chk("unpowered_writes", 8'(wr_cnt - w0), 8'h00);
    #1 supplies_ok = 1'b1;
    repeat (4) @(posedge core_clk);
    wr_case(2'b00, 4'h1, 2'h0, 8'h3C);
    $display("test supplies done");
    close_out();
  end
endmodule
`default_nettype wire
